// ==== verilog/monitored_wait_ctrl.sv ====
// Armed-wait instruction sequencer with APB control and status
`timescale 1ns/1ps
module monitored_wait_ctrl
  import wait_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Instruction issue
  input  wire logic        exec_in,
  input  wire logic [31:0] hint_operand_in,
  input  wire logic [63:0] extension_operand_wide_in,
  input  wire logic [1:0]  cpl_in,
  input  wire logic        v86_in,
  input  wire logic        mode64_in,
  input  wire logic        interrupt_enable_flag_in,
  // Monitor hardware
  input  wire logic        arm_in,
  input  wire logic        store_hit_in,
  input  wire logic        store_proc_in,
  // Wake events
  input  wire logic        ext_intr_in,
  input  wire logic        nmi_in,
  input  wire logic        system_mgmt_interrupt_in,
  input  wire logic        debug_exc_in,
  input  wire logic        mcheck_in,
  input  wire logic        bus_init_pin_in,
  input  wire logic        init_in,
  input  wire logic        reset_req_in,
  // Results
  output logic             retire_out,
  output logic             invalid_opcode_fault_out,
  output logic             general_protection_fault_out,
  output logic             wait_active_out,
  output logic [3:0]       wait_state_out,
  output logic [3:0]       sub_state_out,
  output logic             monitor_armed_out,
  // Feature query words
  output logic [31:0]      leaf1_ext_out,
  output logic [31:0]      leaf5_ext_out,
  // Interrupt
  output logic             irq_out
);
  // Reset release synchroniser
  // Asserts at once, releases on an edge so no flop sees a runt release
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  // State
  seq_state_e      state_r;
  seq_state_e      state_nxt;
  logic [31:0]     ctrl_r;
  logic [EV_W-1:0] stat_r;
  logic [EV_W-1:0] mask_r;
  logic            armed_r;
  logic            intr_wake_r;
  logic [3:0]      tgt_r;
  logic [3:0]      sub_r;
  logic            retire_r;
  logic            invop_r;
  logic            prot_r;
  logic [31:0]     prdata_r;

  // Feature flags follow the enable register
  wire mon_en_w  = ctrl_r[CTRL_EN_BIT];
  wire ext_en_w  = ctrl_r[CTRL_EXT_BIT];
  wire is_idle_w = (state_r == ST_IDLE);
  wire is_wait_w = (state_r == ST_WAIT);
  assign leaf1_ext_out = {28'h0, mon_en_w, 3'h0};
  assign leaf5_ext_out = {31'h0, ext_en_w};

  // Fault decode
  logic invop_w;
  logic prot_w;
  wait_fault_check u_fault (
    .mon_flag_in (mon_en_w),
    .ext_flag_in (ext_en_w),
    .cpl_in      (cpl_in),
    .v86_in      (v86_in),
    .mode64_in   (mode64_in),
    .ext_op_in   (extension_operand_wide_in),
    .invop_out   (invop_w),
    .prot_out    (prot_w)
  );

  // Instruction acceptance
  wire take_w  = exec_in & is_idle_w;
  wire clean_w = take_w & ~invop_w & ~prot_w;
  wire skip_w  = clean_w & ~armed_r;
  wire enter_w = clean_w & armed_r;

  // hint decode, optional override of the hint
  wire [3:0] hint_tgt_w = hint_operand_in[HINT_STATE_LSB +: STATE_W];
  wire [3:0] hint_sub_w = hint_operand_in[HINT_SUB_LSB +: STATE_W];
  wire [3:0] pick_tgt_w = ctrl_r[CTRL_OVR_BIT] ? ctrl_r[CTRL_OVR_LSB +: STATE_W] : hint_tgt_w;

  // Events that wake whatever the state
  // hard wake events; management interrupt ends wait, never restarts it
  wire hard_w = nmi_in | system_mgmt_interrupt_in | debug_exc_in | mcheck_in
              | bus_init_pin_in | init_in | reset_req_in;
  logic wake_w;
  wait_wake_detect u_wake (
    .store_hit_in  (store_hit_in),
    .store_proc_in (store_proc_in),
    .target_in     (tgt_r),
    .ext_intr_in   (ext_intr_in),
    .if_flag_in    (interrupt_enable_flag_in),
    .intr_wake_in  (intr_wake_r),
    .hard_event_in (hard_w),
    .wake_out      (wake_w)
  );
  wire leave_w = is_wait_w & wake_w;

  // Next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: if (enter_w) state_nxt = ST_WAIT;
      ST_WAIT: if (wake_w) state_nxt = ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r  <= ST_IDLE;
      retire_r <= 1'b0;
      invop_r  <= 1'b0;
      prot_r   <= 1'b0;
    end
    else
    begin
      state_r  <= state_nxt;
      // resume at next instruction; skip retires at once
      retire_r <= skip_w | leave_w;
      invop_r  <= take_w & invop_w;
      prot_r   <= take_w & prot_w;
    end
  end

  // Operands latched on entry; same path in every mode
  // extension bit 0 kept for the wake filter
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tgt_r       <= STATE_FIRST;
      sub_r       <= 4'h0;
      intr_wake_r <= 1'b0;
    end
    else if (enter_w)
    begin
      tgt_r       <= pick_tgt_w;
      sub_r       <= hint_sub_w;
      intr_wake_r <= extension_operand_wide_in[EXT_WAKE_BIT];
    end
  end

  // Monitor armed flag; arming beats consumption in the same cycle
  // wait consumes the arming; a monitored store also triggers it
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
      armed_r <= 1'b0;
    else if (arm_in)
      armed_r <= 1'b1;
    else if (enter_w | store_hit_in)
      armed_r <= 1'b0;
  end

  // APB decode; zero wait states
  // Reads have no side effects, so a repeated read is harmless
  wire acc_w     = psel_in & penable_in;
  wire setup_w   = psel_in & ~penable_in;
  wire hit_ctrl  = (paddr_in == CTRL_OFS);
  wire hit_stat  = (paddr_in == STATUS_OFS);
  wire hit_feat  = (paddr_in == FEATURE_OFS);
  wire hit_ist   = (paddr_in == INT_STAT_OFS);
  wire hit_imsk  = (paddr_in == INT_MASK_OFS);
  wire hit_l5    = (paddr_in == LEAF5_OFS);
  wire mapped_w  = hit_ctrl | hit_stat | hit_feat | hit_ist | hit_imsk | hit_l5;
  wire wr_w      = acc_w & pwrite_in;
  wire [31:0] status_w = {16'h0, sub_r, tgt_r, 6'h0, is_wait_w, armed_r};
  wire [31:0] rd_w = hit_ctrl ? ctrl_r
                   : hit_stat ? status_w
                   : hit_feat ? leaf1_ext_out
                   : hit_ist  ? {28'h0, stat_r}
                   : hit_imsk ? {28'h0, mask_r}
                   : hit_l5   ? leaf5_ext_out
                   : 32'h0;
  assign pready_out  = 1'b1;
  assign pslverr_out = acc_w & ~mapped_w;

  // Read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
      prdata_r <= 32'h0;
    else if (setup_w & ~pwrite_in)
      prdata_r <= rd_w;
  end

  // Control and mask writes
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= CTRL_RST;
      mask_r <= EV_RST;
    end
    else
    begin
      if (wr_w & hit_ctrl)
        ctrl_r <= {24'h0, pwdata_in[7:4], 1'b0, pwdata_in[2:0]};
      if (wr_w & hit_imsk)
        mask_r <= pwdata_in[EV_W-1:0];
    end
  end

  // Sticky events, write one to clear; a new event beats the clear
  wire [EV_W-1:0] ev_w;
  assign ev_w[EV_PROT]  = take_w & prot_w;
  assign ev_w[EV_INVOP] = take_w & invop_w;
  assign ev_w[EV_WAKE] = leave_w;
  assign ev_w[EV_SKIP] = skip_w;
  wire [EV_W-1:0] clr_w = (wr_w & hit_ist) ? pwdata_in[EV_W-1:0] : EV_RST;
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
      stat_r <= EV_RST;
    else
      stat_r <= (stat_r & ~clr_w) | ev_w;
  end

  // Outputs
  assign prdata_out        = prdata_r;
  assign retire_out        = retire_r;
  assign invalid_opcode_fault_out     = invop_r;
  assign general_protection_fault_out = prot_r;
  assign wait_active_out   = is_wait_w;
  assign wait_state_out    = tgt_r;
  assign sub_state_out     = sub_r;
  assign monitor_armed_out = armed_r;
  assign irq_out           = |(stat_r & mask_r);

  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n);

  priv_refuse_a: assert property (
    take_w && mon_en_w && !v86_in && cpl_in != 2'h0
    |=> invalid_opcode_fault_out && !retire_out)
    else $error("nonzero privilege not refused");
  feat_off_a: assert property (
    take_w && !mon_en_w |-> !leaf1_ext_out[LEAF1_MON_BIT] ##1 invalid_opcode_fault_out)
    else $error("disabled feature not refused");
  v86_refuse_a: assert property (
    take_w && v86_in
    |=> invalid_opcode_fault_out && !general_protection_fault_out && !wait_active_out)
    else $error("v86 use not refused");
  rsvd_fault_a: assert property (
    take_w && !invop_w && extension_operand_wide_in[31:1] != 31'h0
    |=> general_protection_fault_out)
    else $error("reserved bits not faulted");
  ext_fault_a: assert property (
    take_w && !invop_w && extension_operand_wide_in[0] && !ext_en_w
    |=> general_protection_fault_out)
    else $error("unsupported extension not faulted");
  skip_wait_a: assert property (
    take_w && !invop_w && !prot_w && !armed_r |=> retire_out && !wait_active_out)
    else $error("wait entered with nothing armed");
  mgmt_resume_a: assert property (
    is_wait_w && system_mgmt_interrupt_in
    |=> retire_out && !wait_active_out ##1 !wait_active_out)
    else $error("wait restarted after management interrupt");
  store_trig_a: assert property (
    armed_r && store_hit_in && !arm_in |=> !monitor_armed_out)
    else $error("monitored store did not trigger");
  consume_arm_a: assert property (
    enter_w && !arm_in |=> !monitor_armed_out && wait_active_out)
    else $error("arming not consumed");
  hard_wake_a: assert property (
    is_wait_w && (nmi_in || system_mgmt_interrupt_in) |=> retire_out ##1 !retire_out)
    else $error("hard event did not wake");
  intr_wake_a: assert property (
    is_wait_w && ext_intr_in && intr_wake_r |=> retire_out && !wait_active_out)
    else $error("interrupt with extension did not wake");
  deep_store_a: assert property (
    is_wait_w && tgt_r == 4'h2 && !ext_intr_in && !hard_w && store_hit_in && !store_proc_in
    |=> wait_active_out)
    else $error("non-processor store woke deep state");
  hint_pick_a: assert property (
    enter_w && !ctrl_r[CTRL_OVR_BIT] |=> wait_state_out == $past(hint_tgt_w))
    else $error("target state not taken from hint");

  skip_c: cover property (skip_w);
  wake_c: cover property (enter_w ##[1:20] leave_w);
  prot_c: cover property (take_w && prot_w);
  invop_c: cover property (take_w && invop_w);
  store_wake_c: cover property (is_wait_w && store_hit_in && store_proc_in);
endmodule

// ==== verilog/wait_pkg.sv ====
// Constants and types shared by the monitored wait sequencer
package wait_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] FEATURE_OFS  = 8'h08;
  localparam logic [7:0] INT_STAT_OFS = 8'h0C;
  localparam logic [7:0] INT_MASK_OFS = 8'h10;
  localparam logic [7:0] LEAF5_OFS    = 8'h14;
  // Control fields
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int CTRL_OVR_BIT = 2;
  localparam int CTRL_OVR_LSB = 4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  // Status fields
  localparam int STAT_ARMED_BIT = 0;
  localparam int STAT_WAIT_BIT  = 1;
  localparam int STAT_TGT_LSB   = 8;
  localparam int STAT_SUB_LSB   = 12;
  // Feature query bits
  localparam int LEAF1_MON_BIT = 3;
  localparam int LEAF5_EXT_BIT = 0;
  // Operand fields
  localparam int EXT_WAKE_BIT   = 0;
  localparam int HINT_SUB_LSB   = 0;
  localparam int HINT_STATE_LSB = 4;
  localparam int STATE_W        = 4;
  localparam logic [3:0] STATE_FIRST   = 4'h0;
  localparam logic [3:0] STATE_RUNNING = 4'hF;
  // Interrupt event bits
  localparam int EV_PROT  = 0;
  localparam int EV_INVOP = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_SKIP = 3;
  localparam int EV_W    = 4;
  localparam logic [EV_W-1:0] EV_RST = 4'h0;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } seq_state_e;
endpackage

// ==== verilog/wait_fault_check.sv ====
// Fault decode for the armed-wait instruction
`timescale 1ns/1ps
module wait_fault_check
  import wait_pkg::*;
(
  // Feature state
  input  wire logic        mon_flag_in,
  input  wire logic        ext_flag_in,
  // Execution context
  input  wire logic [1:0]  cpl_in,
  input  wire logic        v86_in,
  input  wire logic        mode64_in,
  input  wire logic [63:0] ext_op_in,
  // Faults
  output logic             invop_out,
  output logic             prot_out
);
  wire upper_w = mode64_in & (|ext_op_in[63:32]);
  wire low_w   = |ext_op_in[31:1];
  // privilege check, disabled feature, v86 refusal
  assign invop_out = ~mon_flag_in | v86_in | (cpl_in != 2'h0);
  // reserved bits; upper half counts only in 64-bit mode
  assign prot_out = ~invop_out & (upper_w | low_w | (ext_op_in[EXT_WAKE_BIT] & ~ext_flag_in));
endmodule

// ==== verilog/wait_wake_detect.sv ====
// Wake event decode for the optimized wait state
`timescale 1ns/1ps
module wait_wake_detect
  import wait_pkg::*;
(
  // Store snoop
  input  wire logic       store_hit_in,
  input  wire logic       store_proc_in,
  input  wire logic [3:0] target_in,
  // Interrupt side
  input  wire logic       ext_intr_in,
  input  wire logic       if_flag_in,
  input  wire logic       intr_wake_in,
  // Always-wake events
  input  wire logic       hard_event_in,
  output logic            wake_out
);
  // Deep states lose wakes from non-processor stores
  wire deep_w = (target_in != STATE_FIRST) & (target_in != STATE_RUNNING);
  wire store_w = store_hit_in & (store_proc_in | ~deep_w);
  wire intr_w = ext_intr_in & (if_flag_in | intr_wake_in);
  assign wake_out = store_w | intr_w | hard_event_in;
endmodule

// ==== sim/monitored_wait_ctrl_tb.sv ====
// Self-checking bench for the armed-wait sequencer
`timescale 1ns/1ps
module monitored_wait_ctrl_tb;
  import wait_pkg::*;
  logic        clock_in, nrst_in, psel_in, penable_in, pwrite_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, hint_operand_in, leaf1_ext_out, leaf5_ext_out;
  logic        pready_out, pslverr_out, exec_in, v86_in, mode64_in, interrupt_enable_flag_in;
  logic [63:0] extension_operand_wide_in;
  logic [1:0]  cpl_in;
  logic        arm_in, store_hit_in, store_proc_in, ext_intr_in;
  logic [6:0]  hev;
  logic        retire_out, invalid_opcode_fault_out, general_protection_fault_out;
  logic        wait_active_out, monitor_armed_out, irq_out;
  logic [3:0]  wait_state_out, sub_state_out, r;
  logic [31:0] q;
  logic        e;
  int          bad_count, check_count, cyc, i;
  // Result codes {wait, protection, invalid opcode, retire}
  localparam logic [3:0] R_RET = 4'h1, R_INV = 4'h2, R_PROT = 4'h4, R_WAIT = 4'h8;

  monitored_wait_ctrl uut (
    .clock_in(clock_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .exec_in(exec_in), .hint_operand_in(hint_operand_in),
    .extension_operand_wide_in(extension_operand_wide_in), .cpl_in(cpl_in), .v86_in(v86_in),
    .mode64_in(mode64_in), .interrupt_enable_flag_in(interrupt_enable_flag_in),
    .arm_in(arm_in), .store_hit_in(store_hit_in), .store_proc_in(store_proc_in),
    .ext_intr_in(ext_intr_in), .nmi_in(hev[0]), .system_mgmt_interrupt_in(hev[1]),
    .debug_exc_in(hev[2]), .mcheck_in(hev[3]), .bus_init_pin_in(hev[4]), .init_in(hev[5]),
    .reset_req_in(hev[6]), .retire_out(retire_out),
    .invalid_opcode_fault_out(invalid_opcode_fault_out),
    .general_protection_fault_out(general_protection_fault_out),
    .wait_active_out(wait_active_out),
    .wait_state_out(wait_state_out), .sub_state_out(sub_state_out),
    .monitor_armed_out(monitor_armed_out), .leaf1_ext_out(leaf1_ext_out),
    .leaf5_ext_out(leaf5_ext_out), .irq_out(irq_out)
  );

  // 20 MHz clock
  initial
  begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end

  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      $display("mismatch at %0t: timeout", $time);
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; waits on pready, never on a fixed count
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    @(posedge clock_in);
    while (pready_out !== 1'b1)
      @(posedge clock_in);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk({31'h0, pready_out}, 32'h1, "ready");
    chk(q, exp, "read data");
    chk({31'h0, e}, {31'h0, err}, "slave error");
  endtask

  // Issue the instruction and sample the registered answer a cycle later
  task automatic issue(input logic [31:0] h, input logic [63:0] x);
    @(posedge clock_in);
    hint_operand_in <= h;
    extension_operand_wide_in <= x;
    exec_in <= 1'b1;
    @(posedge clock_in);
    exec_in <= 1'b0;
    #1;
    r = {wait_active_out, general_protection_fault_out, invalid_opcode_fault_out, retire_out};
  endtask

  // Arm the range, then wait and check the latched target state
  task automatic enter(input logic [31:0] h, input logic [63:0] x, input logic [3:0] st);
    @(posedge clock_in);
    arm_in <= 1'b1;
    @(posedge clock_in);
    arm_in <= 1'b0;
    #1;
    chk({31'h0, monitor_armed_out}, 32'h1, "armed");
    issue(h, x);
    chk({28'h0, r}, {28'h0, R_WAIT}, "wait entry");
    chk({23'h0, monitor_armed_out, wait_state_out, sub_state_out},
        {23'h0, 1'b0, st, h[3:0]}, "armed/state");
  endtask

  // One-cycle wake stimulus, then check retire and wait level
  task automatic poke(input logic [6:0] hv, input logic ei, input logic sh, input logic sp,
                      input logic want);
    @(posedge clock_in);
    hev <= hv;
    ext_intr_in <= ei;
    store_hit_in <= sh;
    store_proc_in <= sp;
    @(posedge clock_in);
    hev <= 7'h0;
    ext_intr_in <= 1'b0;
    store_hit_in <= 1'b0;
    store_proc_in <= 1'b0;
    #1;
    chk({30'h0, retire_out, wait_active_out}, want ? 32'h2 : 32'h1, "wake");
  endtask

  // Fault table: cpl, v86, mode64, extension operand, hint, expected result
  logic [1:0]  t_cpl [10] = '{2'h3, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h0, 2'h0};
  logic        t_v86 [10] = '{0, 0, 1, 0, 0, 0, 0, 0, 0, 0};
  logic        t_m64 [10] = '{0, 0, 0, 0, 0, 1, 0, 0, 1, 0};
  logic [63:0] t_ext [10] = '{64'h0, 64'h0, 64'h0, 64'h2, 64'h8000_0000, 64'h1_0000_0000,
                              64'h1_0000_0000, 64'h2, 64'h1, 64'h0};
  logic [31:0] t_hnt [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
                              32'hFFFF_FF00};
  logic [3:0]  t_res [10] = '{R_INV, R_INV, R_INV, R_PROT, R_PROT, R_PROT, R_RET, R_INV, R_RET,
                              R_RET};

  initial
  begin
    {psel_in, penable_in, pwrite_in, exec_in, v86_in, mode64_in} = 6'h0;
    {arm_in, store_hit_in, store_proc_in, ext_intr_in, interrupt_enable_flag_in} = 5'h0;
    {paddr_in, pwdata_in, hint_operand_in, extension_operand_wide_in} = 136'h0;
    {cpl_in, hev, bad_count, check_count, cyc} = 0;
    nrst_in = 1'b0;
    repeat (4) @(posedge clock_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    // Reset values, read-only and unmapped places
    rd(CTRL_OFS, CTRL_RST, 1'b0);
    rd(FEATURE_OFS, 32'h8, 1'b0);
    chk(leaf1_ext_out, 32'h8, "leaf1 flag");
    rd(LEAF5_OFS, 32'h1, 1'b0);
    rd(INT_MASK_OFS, 32'h0, 1'b0);
    apb(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
    rd(STATUS_OFS, 32'h0, 1'b0);
    rd(8'h18, 32'h0, 1'b1);
    $display("test registers done");
    // Privilege, mode and reserved-bit faults, not armed otherwise
    for (i = 0; i < 10; i++)
    begin
      @(posedge clock_in);
      cpl_in <= t_cpl[i];
      v86_in <= t_v86[i];
      mode64_in <= t_m64[i];
      issue(t_hnt[i], t_ext[i]);
      chk({28'h0, r}, {28'h0, t_res[i]}, "fault table");
    end
    @(posedge clock_in);
    mode64_in <= 1'b0;
    $display("test faults done");
    // Feature disable and extension support withdrawn
    apb(1'b1, CTRL_OFS, 32'h2);
    rd(FEATURE_OFS, 32'h0, 1'b0);
    chk(leaf1_ext_out, 32'h0, "leaf1 cleared");
    issue(32'h0, 64'h0);
    chk({28'h0, r}, {28'h0, R_INV}, "disabled");
    apb(1'b1, CTRL_OFS, 32'h1);
    #1;
    chk(leaf5_ext_out, 32'h0, "leaf5");
    issue(32'h0, 64'h1);
    chk({28'h0, r}, {28'h0, R_PROT}, "no ext support");
    apb(1'b1, CTRL_OFS, 32'h3);
    $display("test enables done");
    // Every hard event ends the wait and resumes at the next instruction
    for (i = 0; i < 7; i++)
    begin
      enter(32'h03, 64'h0, 4'h0);
      if (i == 0)
        poke(7'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      poke(7'h1 << i, 1'b0, 1'b0, 1'b0, 1'b1);
    end
    // The wait consumed the arming, so a second wait is skipped
    issue(32'h0, 64'h0);
    chk({28'h0, r}, {28'h0, R_RET}, "rearm needed");
    $display("test hard events done");
    // External interrupt: masked, deliverable, masked with wake request
    enter(32'h10, 64'h0, 4'h1);
    poke(7'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge clock_in);
    interrupt_enable_flag_in <= 1'b1;
    poke(7'h0, 1'b1, 1'b0, 1'b0, 1'b1);
    @(posedge clock_in);
    interrupt_enable_flag_in <= 1'b0;
    enter(32'h10, 64'h1, 4'h1);
    poke(7'h0, 1'b1, 1'b0, 1'b0, 1'b1);
    $display("test interrupts done");
    // Stores: deep state needs a processor agent, shallow ones do not
    enter(32'h25, 64'h0, 4'h2);
    poke(7'h0, 1'b0, 1'b1, 1'b0, 1'b0);
    poke(7'h0, 1'b0, 1'b1, 1'b1, 1'b1);
    enter(32'hF0, 64'h0, STATE_RUNNING);
    poke(7'h0, 1'b0, 1'b1, 1'b0, 1'b1);
    enter(32'h07, 64'h0, STATE_FIRST);
    poke(7'h0, 1'b0, 1'b1, 1'b0, 1'b1);
    // Hint override picks a different state
    apb(1'b1, CTRL_OFS, 32'h37);
    enter(32'h10, 64'h0, 4'h3);
    poke(7'h1, 1'b0, 1'b0, 1'b0, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h3);
    // Store lands between arming and the wait: software must see it
    @(posedge clock_in);
    arm_in <= 1'b1;
    @(posedge clock_in);
    arm_in <= 1'b0;
    store_hit_in <= 1'b1;
    @(posedge clock_in);
    store_hit_in <= 1'b0;
    #1;
    chk({31'h0, monitor_armed_out}, 32'h0, "triggered before wait");
    issue(32'h0, 64'h0);
    chk({28'h0, r}, {28'h0, R_RET}, "wait after trigger");
    $display("test stores done");
    // Sticky events, mask and write-one-to-clear
    rd(INT_STAT_OFS, 32'hF, 1'b0);
    chk({31'h0, irq_out}, 32'h0, "irq masked");
    apb(1'b1, INT_MASK_OFS, 32'h4);
    #1;
    chk({31'h0, irq_out}, 32'h1, "irq raised");
    apb(1'b1, INT_STAT_OFS, 32'h4);
    #1;
    chk({31'h0, irq_out}, 32'h0, "irq cleared");
    rd(INT_STAT_OFS, 32'hB, 1'b0);
    $display("test irq done");
    complete_run();
  end
endmodule
